// >>> rtl/fsr_map.vh
// Status bank field positions, reset values and instruction codes
// Function
// - Pause tristates output, ignores input and clock
// - Pause keeps bit position, shifting resumes after
// - Select high during pause resets interface
// - Pause starts on pin fall, clock low
// - Pause ends on pin rise, clock low
// - Third register bit 7 selects pause/reset pin
// - Third register bits 6:5 drive strength
// - Third register bit 2 selects protect scheme
// - Second register bit 7 erase suspended, read-only
// - Second register bit 6 inverts protection map
// - Second register bits 5:3 one-time lock bits
// - Second register bit 1 enables quad mode
// - Second register bit 0 status protect one
// - First register bit 7 status protect zero
// - First register bit 6 block/sector granularity
// - First register bit 5 top/bottom direction
// - First register bits 4:2 protect range
// - First register bit 1 write-enable latch, read-only
// - First register bit 0 busy flag, read-only
// - Suspend sets flag, resume clears it
// - Pause/reset only while quad enable is 0
`ifndef FSR_MAP_VH
`define FSR_MAP_VH
`define FSR_S3_PINFN_BIT   7
`define FSR_S3_DRV_HI_BIT  6
`define FSR_S3_DRV_LO_BIT  5
`define FSR_S3_WPS_BIT     2
`define FSR_S3_WR_MASK     8'hE4
`define FSR_S3_RESET       8'h00
`define FSR_S2_SUS_BIT     7
`define FSR_S2_INV_BIT     6
`define FSR_S2_LOCK_HI     5
`define FSR_S2_LOCK_LO     3
`define FSR_S2_RSV_BIT     2
`define FSR_S2_QE_BIT      1
`define FSR_S2_SP1_BIT     0
`define FSR_S2_WR_MASK     8'h43
`define FSR_S2_RESET       8'h04
`define FSR_S1_SP0_BIT     7
`define FSR_S1_WR_MASK     8'hFC
`define FSR_S1_RESET       8'h00
`define FSR_S1_WEL_BIT     1
`define FSR_S1_BUSY_BIT    0
`define FSR_CMD_WREN       8'h06
`define FSR_CMD_WRDI       8'h04
`define FSR_CMD_RDSR1      8'h05
`define FSR_CMD_RDSR2      8'h35
`define FSR_CMD_RDSR3      8'h15
`define FSR_CMD_WRSR1      8'h01
`define FSR_CMD_WRSR2      8'h31
`define FSR_CMD_WRSR3      8'h11
`define FSR_CMD_SUSPEND    8'h75
`define FSR_CMD_RESUME     8'h7A
`define FSR_WR_BUSY_NS     1000
`define FSR_CLK_NS         100
`define FSR_WR_BUSY_CYC    ((`FSR_WR_BUSY_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`endif

// >>> rtl/fsr_sync3.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module fsr_sync3 #(
    parameter RST_VAL = 1'b0
) (
    input  wire mclk,
    input  wire rst_n,
    input  wire din,
    output wire dout
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;
    reg out_ff;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff  <= RST_VAL;
            s2_ff  <= RST_VAL;
            s3_ff  <= RST_VAL;
            out_ff <= RST_VAL;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // Change counts only once stages two and three agree
            if (s2_ff == s3_ff) begin
                out_ff <= s3_ff;
            end
        end
    end
    assign dout = out_ff;
endmodule // fsr_sync3
`default_nettype wire

// >>> rtl/fsr_status_bank.v
// Serial status bank with pause handling, sampled on mclk
`timescale 1ns/1ps
`default_nettype none
`include "fsr_map.vh"
module fsr_status_bank #(
    parameter WR_BUSY_CYC = `FSR_WR_BUSY_CYC
) (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       sclk,
    input  wire       cs_n,
    input  wire       si,
    input  wire       pause_rst_n,
    input  wire       wp_n,
    input  wire       op_busy,
    output reg        so_o,
    output reg        so_oe,
    output wire       pin_reset_n,
    output wire [1:0] drive_strength,
    output wire       protect_scheme_select,
    output wire       protect_invert,
    output wire [2:0] secreg_lock,
    output wire       quad_enable_bit,
    output wire       protect_granularity,
    output wire       protect_direction,
    output wire [2:0] protect_range,
    output wire       write_enable_latch_flag,
    output wire       busy_flag,
    output wire       erase_suspended_flag,
    output wire       paused
);
    localparam ST_CMD  = 4'b0001;
    localparam ST_READ = 4'b0010;
    localparam ST_WDAT = 4'b0100;
    localparam ST_IDLE = 4'b1000;

    wire sclk_s;
    wire cs_n_s;
    wire si_s;
    wire pin_s;
    wire wp_s;
    fsr_sync3 #(.RST_VAL(1'b0)) u_sclk (.mclk(mclk), .rst_n(rst_n), .din(sclk),        .dout(sclk_s));
    fsr_sync3 #(.RST_VAL(1'b1)) u_cs   (.mclk(mclk), .rst_n(rst_n), .din(cs_n),        .dout(cs_n_s));
    fsr_sync3 #(.RST_VAL(1'b0)) u_si   (.mclk(mclk), .rst_n(rst_n), .din(si),          .dout(si_s));
    fsr_sync3 #(.RST_VAL(1'b1)) u_pin  (.mclk(mclk), .rst_n(rst_n), .din(pause_rst_n), .dout(pin_s));
    fsr_sync3 #(.RST_VAL(1'b1)) u_wp   (.mclk(mclk), .rst_n(rst_n), .din(wp_n),        .dout(wp_s));

    reg [7:0] sr1_ff;
    reg [7:0] sr2_ff;
    reg [7:0] sr3_ff;
    reg       wel_ff;
    reg       sus_ff;
    reg       pause_ff;
    reg       sclk_d_ff;
    reg       pin_d_ff;
    reg       cs_d_ff;
    reg [3:0] state_ff;
    reg [2:0] bitcnt_ff;
    reg [7:0] shift_ff;
    reg [7:0] cmd_ff;
    reg [7:0] rdat_ff;
    reg [15:0] busy_cnt_ff;
    reg       busy_ff;

    wire sclk_rise = sclk_s & ~sclk_d_ff;
    wire sclk_fall = ~sclk_s & sclk_d_ff;
    wire pin_fall  = ~pin_s & pin_d_ff;
    wire pin_rise  = pin_s & ~pin_d_ff;
    wire pin_is_reset = sr3_ff[`FSR_S3_PINFN_BIT];
    wire qe = sr2_ff[`FSR_S2_QE_BIT];
    wire pause_fn = ~qe & ~pin_is_reset;
    wire hw_reset = ~qe & pin_is_reset & ~pin_s;
    wire active = ~cs_n_s & ~pause_ff & ~hw_reset;
    wire [7:0] nxt_shift = {shift_ff[6:0], si_s};

    // Status register write lock per protect bits and wp
    wire sp1 = sr2_ff[`FSR_S2_SP1_BIT];
    wire sp0 = sr1_ff[`FSR_S1_SP0_BIT];
    wire sr_locked = sp1 | (sp0 & ~wp_s);

    assign pin_reset_n = ~hw_reset;
    assign paused = pause_ff;

    // Pause window tracking
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pause_ff  <= 1'b0;
            sclk_d_ff <= 1'b0;
            pin_d_ff  <= 1'b1;
            cs_d_ff   <= 1'b1;
        end else begin
            sclk_d_ff <= sclk_s;
            pin_d_ff  <= pin_s;
            cs_d_ff   <= cs_n_s;
            if (cs_n_s || !pause_fn) begin
                pause_ff <= 1'b0;
            end else if (!pause_ff && pin_fall && !sclk_s) begin
                pause_ff <= 1'b1;
            end else if (pause_ff && pin_rise && !sclk_s) begin
                pause_ff <= 1'b0;
            end
        end
    end

    // Serial engine; pause freezes bitcnt and state
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff  <= ST_IDLE;
            bitcnt_ff <= 3'd0;
            shift_ff  <= 8'h00;
            cmd_ff    <= 8'h00;
            rdat_ff   <= 8'h00;
            so_o      <= 1'b0;
            so_oe     <= 1'b0;
        end else if (cs_n_s || hw_reset) begin
            // Deselect drops any partial op, also mid-pause
            state_ff  <= ST_IDLE;
            bitcnt_ff <= 3'd0;
            so_oe     <= 1'b0;
        end else if (pause_ff) begin
            so_oe <= 1'b0;
        end else begin
            if (state_ff == ST_IDLE && cs_d_ff) begin
                state_ff <= ST_CMD;
            end
            if (sclk_rise) begin
                case (state_ff)
                    ST_CMD, ST_WDAT: begin
                        shift_ff  <= nxt_shift;
                        bitcnt_ff <= bitcnt_ff + 3'd1;
                        if (bitcnt_ff == 3'd7 && state_ff == ST_CMD) begin
                            cmd_ff <= nxt_shift;
                            case (nxt_shift)
                                `FSR_CMD_RDSR1: begin
                                    state_ff <= ST_READ;
                                    rdat_ff  <= {sr1_ff[7:2], wel_ff, busy_ff};
                                end
                                `FSR_CMD_RDSR2: begin
                                    state_ff <= ST_READ;
                                    rdat_ff  <= {sus_ff, sr2_ff[6:0]};
                                end
                                `FSR_CMD_RDSR3: begin
                                    state_ff <= ST_READ;
                                    rdat_ff  <= sr3_ff;
                                end
                                `FSR_CMD_WRSR1, `FSR_CMD_WRSR2, `FSR_CMD_WRSR3: state_ff <= ST_WDAT;
                                default: state_ff <= ST_IDLE;
                            endcase
                        end else if (bitcnt_ff == 3'd7) begin
                            state_ff <= ST_IDLE;
                        end
                    end
                    default: ;
                endcase
            end
            if (sclk_fall && state_ff == ST_READ) begin
                so_oe   <= 1'b1;
                so_o    <= rdat_ff[7];
                rdat_ff <= {rdat_ff[6:0], rdat_ff[7]};
            end
        end
    end

    // Instruction completion on select rise
    wire cs_rise = cs_n_s & ~cs_d_ff;
    wire cmd_done = cs_rise && !pause_ff && bitcnt_ff == 3'd0;
    wire wr_ok = wel_ff & ~busy_ff & ~sr_locked;
    wire do_wr = cmd_done && state_ff == ST_IDLE && wr_ok &&
                 (cmd_ff == `FSR_CMD_WRSR1 || cmd_ff == `FSR_CMD_WRSR2 || cmd_ff == `FSR_CMD_WRSR3);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sr1_ff      <= `FSR_S1_RESET;
            sr2_ff      <= `FSR_S2_RESET;
            sr3_ff      <= `FSR_S3_RESET;
            wel_ff      <= 1'b0;
            sus_ff      <= 1'b0;
            busy_ff     <= 1'b0;
            busy_cnt_ff <= 16'h0000;
        end else begin
            if (busy_cnt_ff != 16'h0000) begin
                busy_cnt_ff <= busy_cnt_ff - 16'h0001;
            end
            busy_ff <= (busy_cnt_ff > 16'h0001) | op_busy;
            if (cmd_done && cmd_ff == `FSR_CMD_WREN) begin
                wel_ff <= 1'b1;
            end else if (cmd_done && cmd_ff == `FSR_CMD_WRDI) begin
                wel_ff <= 1'b0;
            end
            if (cmd_done && cmd_ff == `FSR_CMD_SUSPEND) begin
                sus_ff <= 1'b1;
            end else if (cmd_done && cmd_ff == `FSR_CMD_RESUME) begin
                sus_ff <= 1'b0;
            end
            if (do_wr) begin
                wel_ff      <= 1'b0;
                busy_cnt_ff <= WR_BUSY_CYC[15:0];
                case (cmd_ff)
                    `FSR_CMD_WRSR1: begin
                        // Writable fields only; flags stay hardware-owned
                        sr1_ff <= (sr1_ff & ~`FSR_S1_WR_MASK) | (shift_ff & `FSR_S1_WR_MASK);
                    end
                    `FSR_CMD_WRSR2: begin
                        // Lock bits only ever go 0 to 1
                        sr2_ff <= ((sr2_ff & ~`FSR_S2_WR_MASK) | (shift_ff & `FSR_S2_WR_MASK)) | (shift_ff & 8'h38);
                    end
                    default: begin
                        sr3_ff <= (sr3_ff & ~`FSR_S3_WR_MASK) | (shift_ff & `FSR_S3_WR_MASK);
                    end
                endcase
            end
        end
    end

    assign drive_strength          = sr3_ff[`FSR_S3_DRV_HI_BIT:`FSR_S3_DRV_LO_BIT];
    assign protect_scheme_select   = sr3_ff[`FSR_S3_WPS_BIT];
    assign protect_invert          = sr2_ff[`FSR_S2_INV_BIT];
    assign secreg_lock             = sr2_ff[`FSR_S2_LOCK_HI:`FSR_S2_LOCK_LO];
    assign quad_enable_bit         = qe;
    assign protect_granularity     = sr1_ff[6];
    assign protect_direction       = sr1_ff[5];
    assign protect_range           = sr1_ff[4:2];
    assign write_enable_latch_flag = wel_ff;
    assign busy_flag               = busy_ff;
    assign erase_suspended_flag    = sus_ff;
endmodule // fsr_status_bank
`default_nettype wire

// >>> tb/fsr_status_bank_properties.sv
// Temporal checks on the status bank ports
`timescale 1ns/1ps
`default_nettype none
module fsr_status_bank_properties #(
    parameter int WR_BUSY_CYC = 10
) (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       cs_n,
    input wire logic       op_busy,
    input wire logic       so_oe,
    input wire logic       pin_reset_n,
    input wire logic       protect_invert,
    input wire logic [2:0] secreg_lock,
    input wire logic       quad_enable_bit,
    input wire logic [2:0] protect_range,
    input wire logic       write_enable_latch_flag,
    input wire logic       busy_flag,
    input wire logic       erase_suspended_flag,
    input wire logic       paused
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [7:0] bcnt_ff;
    // Busy run length from writes only; engine busy is unbounded
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bcnt_ff <= 8'h00;
        end else begin
            bcnt_ff <= (busy_flag && !op_busy) ? bcnt_ff + 8'h01 : 8'h00;
        end
    end
    pause_hiz_out_a : assert property (paused [*3] |-> !so_oe)
        else $error("output driven while paused");
    deselect_idle_a : assert property (cs_n [*8] |-> !paused && !so_oe)
        else $error("pause or output kept while deselected");
    busy_follows_op_a : assert property (op_busy [*3] |-> busy_flag)
        else $error("busy flag low while engine busy");
    busy_bounded_a : assert property (bcnt_ff <= WR_BUSY_CYC + 1)
        else $error("write busy lasts too long");
    lock_sticky_a : assert property (1 |=> (secreg_lock & $past(secreg_lock)) == $past(secreg_lock))
        else $error("lock bit cleared");
    quad_no_pause_a : assert property (quad_enable_bit |-> !paused && pin_reset_n)
        else $error("pin control active in quad mode");
    wel_clear_write_a : assert property ($rose(busy_flag) && !op_busy |-> ##[0:2] !write_enable_latch_flag)
        else $error("write enable latch not cleared by write");
    cfg_change_idle_a : assert property ($changed({erase_suspended_flag, protect_invert, protect_range,
        quad_enable_bit}) |-> cs_n)
        else $error("status changed while selected");
endmodule // fsr_status_bank_properties
bind fsr_status_bank fsr_status_bank_properties #(.WR_BUSY_CYC(WR_BUSY_CYC)) u_props (.*);
`default_nettype wire

// >>> tb/fsr_spi_host.sv
// SPI mode 0 host model driving the status bank pins
`timescale 1ns/1ps
`default_nettype none
module fsr_spi_host (
    input  wire logic mclk,
    input  wire logic so_o,
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic si,
    output var  logic pause_rst_n
);
    // Each sclk phase spans 8 mclk, above what the synchroniser needs
    localparam int PH = 8;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        pause_rst_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic sel();
        cs_n = 1'b0;
        tick(PH);
    endtask
    task automatic shift(input logic [7:0] d, input int n, output logic [7:0] r);
        for (int i = 7; i > 7 - n; i--) begin
            si = d[i];
            tick(PH);
            r = {r[6:0], so_o};
            sclk = 1'b1;
            tick(PH);
            sclk = 1'b0;
        end
    endtask
    task automatic hold(input logic v);
        tick(PH);
        pause_rst_n = v;
        tick(PH);
    endtask
    task automatic desel();
        tick(PH);
        cs_n = 1'b1;
        si = ~si; // Released line must not show a stale bit
        tick(2 * PH);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int n, output logic [7:0] r);
        sel();
        shift(op, 8, r);
        shift(d, n, r);
        desel();
    endtask
endmodule // fsr_spi_host
`default_nettype wire

// >>> tb/fsr_status_bank_tb.sv
// Self-checking bench for the status bank
`timescale 1ns/1ps
`default_nettype none
module fsr_status_bank_tb;
    logic       mclk, rst_n, wp_n, op_busy, sclk, cs_n, si, pause_rst_n, so_o, so_oe, pin_reset_n;
    logic       protect_scheme_select, protect_invert, quad_enable_bit, protect_granularity;
    logic       protect_direction, write_enable_latch_flag, busy_flag, erase_suspended_flag, paused;
    logic [1:0] drive_strength;
    logic [2:0] secreg_lock, protect_range;
    logic [7:0] r;
    int         errors = 0;
    int         n_tests = 0;
    fsr_status_bank #(.WR_BUSY_CYC(3)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .pause_rst_n(pause_rst_n),
        .wp_n(wp_n), .op_busy(op_busy), .so_o(so_o), .so_oe(so_oe), .pin_reset_n(pin_reset_n),
        .drive_strength(drive_strength), .protect_scheme_select(protect_scheme_select),
        .protect_invert(protect_invert), .secreg_lock(secreg_lock), .quad_enable_bit(quad_enable_bit),
        .protect_granularity(protect_granularity), .protect_direction(protect_direction),
        .protect_range(protect_range), .write_enable_latch_flag(write_enable_latch_flag),
        .busy_flag(busy_flag), .erase_suspended_flag(erase_suspended_flag), .paused(paused)
    );
    fsr_spi_host u_host (.mclk(mclk), .so_o(so_o), .sclk(sclk), .cs_n(cs_n), .si(si), .pause_rst_n(pause_rst_n));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] op, input logic [7:0] e, input string nm);
        u_host.cmd(op, 8'h00, 8, r);
        chk(nm, e, r);
    endtask
    task automatic wr(input logic [7:0] op, input logic [7:0] d);
        int k;
        u_host.cmd(8'h06, 8'h00, 0, r);
        u_host.cmd(op, d, 8, r);
        for (k = 0; k < 50 && busy_flag !== 1'b0; k++) begin
            @(negedge mclk);
        end
        if (k == 50) begin
            chk("busy_wait", 8'h00, 8'h01);
            final_report();
        end
    endtask
    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        op_busy = 1'b0;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        u_host.tick(8);
        rd(8'h05, 8'h00, "sr1_reset");
        rd(8'h35, 8'h04, "sr2_reset");
        rd(8'h15, 8'h00, "sr3_reset");
        u_host.cmd(8'h01, 8'hFC, 8, r);
        rd(8'h05, 8'h00, "sr1_no_wel");
        wr(8'h01, 8'hFF);
        rd(8'h05, 8'hFC, "sr1_write");
        chk("protect_fields", 8'h1F, {protect_granularity, protect_direction, protect_range});
        wp_n = 1'b0;
        wr(8'h01, 8'h00);
        // Refused write leaves the latch set
        rd(8'h05, 8'hFE, "sr1_wp_locked");
        wp_n = 1'b1;
        wr(8'h01, 8'h00);
        rd(8'h05, 8'h00, "sr1_unlocked");
        $display("test sr1 done");
        wr(8'h11, 8'hFF);
        rd(8'h15, 8'hE4, "sr3_write");
        chk("drive_wps", 8'h07, {drive_strength, protect_scheme_select});
        u_host.hold(1'b0);
        chk("pin_reset", 8'h00, pin_reset_n);
        u_host.hold(1'b1);
        wr(8'h11, 8'h00);
        $display("test sr3 done");
        wr(8'h31, 8'h78);
        rd(8'h35, 8'h7C, "sr2_write");
        chk("protect_invert", 8'h01, protect_invert);
        wr(8'h31, 8'h00);
        rd(8'h35, 8'h3C, "sr2_otp");
        chk("secreg_lock", 8'h07, secreg_lock);
        u_host.cmd(8'h75, 8'h00, 0, r);
        rd(8'h35, 8'hBC, "suspended");
        u_host.cmd(8'h7A, 8'h00, 0, r);
        chk("resumed", 8'h00, erase_suspended_flag);
        $display("test sr2 done");
        op_busy = 1'b1;
        u_host.tick(8);
        chk("busy_op", 8'h01, busy_flag);
        u_host.cmd(8'h06, 8'h00, 0, r);
        u_host.cmd(8'h01, 8'h1C, 8, r);
        op_busy = 1'b0;
        u_host.cmd(8'h04, 8'h00, 0, r);
        rd(8'h05, 8'h00, "busy_refused");
        $display("test busy done");
        u_host.cmd(8'h06, 8'h00, 0, r);
        u_host.sel();
        u_host.shift(8'h05, 4, r);
        u_host.hold(1'b0);
        chk("paused", 8'h01, paused);
        chk("hiz", 8'h00, so_oe);
        u_host.shift(8'hFF, 3, r);
        u_host.hold(1'b1);
        chk("unpaused", 8'h00, paused);
        u_host.shift(8'h50, 4, r);
        u_host.shift(8'h00, 8, r);
        u_host.desel();
        chk("read_after_pause", 8'h02, r);
        u_host.sel();
        u_host.shift(8'h04, 8, r);
        u_host.hold(1'b0);
        u_host.desel();
        u_host.hold(1'b1);
        rd(8'h05, 8'h02, "abort_kept_wel");
        u_host.hold(1'b0);
        chk("deselected_pause", 8'h00, paused);
        u_host.hold(1'b1);
        $display("test pause done");
        wr(8'h31, 8'h02);
        u_host.sel();
        u_host.hold(1'b0);
        chk("quad_no_pause", 8'h00, paused);
        u_host.hold(1'b1);
        u_host.desel();
        rd(8'h35, 8'h3E, "quad_set");
        chk("quad_enable", 8'h01, quad_enable_bit);
        $display("test quad done");
        final_report();
    end
endmodule // fsr_status_bank_tb
`default_nettype wire
